// ---- audio_sync_control_regs.sv ----
// Function
// - Bit 6 raises AGC up threshold.
// - Bit 5 raises AGC down threshold.
// - Bits 4:3 pick gain-decrease decay time.
// - Bits 2:1 pick gain-increase decay time.
// - Bit 0 turns automatic gain on.
// - Precharge-off bit acts only when manual.
// - Bit 6 picks automatic or manual precharge.
// - Five-bit gain, -6dB to 25dB, 1dB steps.
// - Bit 0 switches audio buffer amplifier.
// - Bit 7 picks shared pin or fourth output.
// - Pull-down: off when set, buffer on, audio.
// - Bits 4:3 pick audio decay time.
// - Three-bit selector picks effect; 111 reserved.
// - Bits 3:0 put outputs into audio mode.
// - AGC starts at gain, stays within 3dB.
// - Audio-mode output driven by audio unit.
`timescale 1ns/1ps
module audio_sync_control_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic audio_mode_active,
  input wire logic [3:0] pattern_level,
  input wire logic [3:0] sound_level,
  output logic [3:0] drive_level,
  output logic agc_up_threshold_high,
  output logic agc_down_threshold_high,
  output logic [10:0] agc_down_decay_ms,
  output logic [10:0] agc_up_decay_ms,
  output logic agc_enable,
  output logic precharge_manual,
  output logic precharge_enable,
  output logic signed [5:0] preamp_gain_db,
  output logic signed [5:0] agc_gain_min_db,
  output logic signed [5:0] agc_gain_max_db,
  output logic audio_buffer_on,
  output logic source_is_fourth_current_output,
  output logic pulldown_enable,
  output logic [6:0] audio_decay_ms,
  output audio_sync_pkg::sync_effect_e sync_effect,
  output logic effect_valid,
  output logic out1_sound_drive,
  output logic out2_sound_drive,
  output logic out3_sound_drive,
  output logic out4_sound_drive
);

  audio_sync_pkg::ctrl_state_s s;
  audio_sync_pkg::ctrl_state_s next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic wr_fire;
  logic [7:0] rd_now;
  logic [7:0] rd_next;
  logic [7:0] ptr_inc;

  function automatic logic [7:0] read_reg(
    input audio_sync_pkg::audio_regs_s regs,
    input logic [7:0] ptr
  );
    logic [7:0] value;
    value = 8'h00;
    unique case (ptr)
      audio_sync_pkg::GAIN_LOOP_OFFSET: value = regs.gain_loop_setup;
      audio_sync_pkg::INPUT_BUFFER_OFFSET: value = regs.input_buffer_setup;
      audio_sync_pkg::SYNC_EFFECT_OFFSET: value = regs.sync_effect_setup;
      audio_sync_pkg::CHANNEL_SOURCE_OFFSET: value = regs.channel_source_select;
      default: value = 8'h00;
    endcase
    return value;
  endfunction

  function automatic audio_sync_pkg::audio_regs_s write_reg(
    input audio_sync_pkg::audio_regs_s regs,
    input logic [7:0] ptr,
    input logic [7:0] data
  );
    audio_sync_pkg::audio_regs_s r;
    r = regs;
    unique case (ptr)
      audio_sync_pkg::GAIN_LOOP_OFFSET:
        r.gain_loop_setup = data & audio_sync_pkg::GAIN_LOOP_MASK;
      audio_sync_pkg::INPUT_BUFFER_OFFSET:
        r.input_buffer_setup = data & audio_sync_pkg::INPUT_BUFFER_MASK;
      audio_sync_pkg::SYNC_EFFECT_OFFSET:
        r.sync_effect_setup = data & audio_sync_pkg::SYNC_EFFECT_MASK;
      audio_sync_pkg::CHANNEL_SOURCE_OFFSET:
        r.channel_source_select = data & audio_sync_pkg::CHANNEL_SOURCE_MASK;
      default: r = regs;
    endcase
    return r;
  endfunction

  assign scl_rise = s.scl_sync & ~s.scl_prev;
  assign scl_fall = ~s.scl_sync & s.scl_prev;
  assign start_seen = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
  assign stop_seen = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;
  assign ptr_inc = s.ptr + 8'h01;
  assign rd_now = read_reg(s.regs, s.ptr);
  assign rd_next = read_reg(s.regs, ptr_inc);

  always_comb begin
    next_s = s;
    wr_fire = 1'b0;
    next_s.scl_meta = scl_in;
    next_s.scl_sync = s.scl_meta;
    next_s.scl_prev = s.scl_sync;
    next_s.sda_meta = sda_in;
    next_s.sda_sync = s.sda_meta;
    next_s.sda_prev = s.sda_sync;
    if (stop_seen) begin
      next_s.fsm = audio_sync_pkg::ST_IDLE;
      next_s.drive = 1'b0;
    end else if (start_seen) begin
      next_s.fsm = audio_sync_pkg::ST_ADDR;
      next_s.bit_cnt = 4'h0;
      next_s.drive = 1'b0;
    end else begin
      unique case (s.fsm)
        audio_sync_pkg::ST_IDLE: begin
          next_s.drive = 1'b0;
        end
        audio_sync_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], s.sda_sync};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == 4'h8) begin
            next_s.bit_cnt = 4'h0;
            if (s.shift[7:1] == audio_sync_pkg::DEVICE_ADDR) begin
              next_s.rw = s.shift[0];
              next_s.drive = 1'b1;
              next_s.fsm = audio_sync_pkg::ST_ADDR_ACK;
            end else begin
              next_s.fsm = audio_sync_pkg::ST_IDLE;
            end
          end
        end
        audio_sync_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            next_s.bit_cnt = 4'h0;
            if (s.rw) begin
              next_s.shift = rd_now;
              next_s.drive = ~rd_now[7];
              next_s.fsm = audio_sync_pkg::ST_READ;
            end else begin
              next_s.drive = 1'b0;
              next_s.fsm = audio_sync_pkg::ST_PTR;
            end
          end
        end
        audio_sync_pkg::ST_PTR: begin
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], s.sda_sync};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == 4'h8) begin
            next_s.bit_cnt = 4'h0;
            next_s.ptr = s.shift;
            next_s.drive = 1'b1;
            next_s.fsm = audio_sync_pkg::ST_PTR_ACK;
          end
        end
        audio_sync_pkg::ST_PTR_ACK: begin
          if (scl_fall) begin
            next_s.drive = 1'b0;
            next_s.fsm = audio_sync_pkg::ST_WRITE;
          end
        end
        audio_sync_pkg::ST_WRITE: begin
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], s.sda_sync};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == 4'h8) begin
            wr_fire = 1'b1;
            next_s.regs = write_reg(s.regs, s.ptr, s.shift);
            next_s.ptr = ptr_inc;
            next_s.bit_cnt = 4'h0;
            next_s.drive = 1'b1;
            next_s.fsm = audio_sync_pkg::ST_WRITE_ACK;
          end
        end
        audio_sync_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            next_s.drive = 1'b0;
            next_s.fsm = audio_sync_pkg::ST_WRITE;
          end
        end
        audio_sync_pkg::ST_READ: begin
          if (scl_fall) begin
            if (s.bit_cnt == 4'h7) begin
              next_s.bit_cnt = 4'h0;
              next_s.drive = 1'b0;
              next_s.fsm = audio_sync_pkg::ST_READ_ACK;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.drive = ~s.shift[6];
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
          end
        end
        audio_sync_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            next_s.nack = s.sda_sync;
          end else if (scl_fall) begin
            if (!s.nack) begin
              next_s.ptr = ptr_inc;
              next_s.shift = rd_next;
              next_s.drive = ~rd_next[7];
              next_s.fsm = audio_sync_pkg::ST_READ;
            end else begin
              next_s.fsm = audio_sync_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          next_s.fsm = audio_sync_pkg::ST_IDLE;
          next_s.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.scl_meta <= 1'b1;
      s.scl_sync <= 1'b1;
      s.scl_prev <= 1'b1;
      s.sda_meta <= 1'b1;
      s.sda_sync <= 1'b1;
      s.sda_prev <= 1'b1;
      s.fsm <= audio_sync_pkg::ST_IDLE;
      s.regs.gain_loop_setup <= audio_sync_pkg::GAIN_LOOP_RESET;
      s.regs.input_buffer_setup <= audio_sync_pkg::INPUT_BUFFER_RESET;
      s.regs.sync_effect_setup <= audio_sync_pkg::SYNC_EFFECT_RESET;
      s.regs.channel_source_select <= audio_sync_pkg::CHANNEL_SOURCE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_drive_n = ~s.drive;

  assign agc_up_threshold_high = s.regs.gain_loop_setup[audio_sync_pkg::AGC_UP_LEVEL_BIT];
  assign agc_down_threshold_high = s.regs.gain_loop_setup[audio_sync_pkg::AGC_DOWN_LEVEL_BIT];
  assign agc_enable = s.regs.gain_loop_setup[audio_sync_pkg::AGC_ON_BIT];

  always_comb begin
    unique case (s.regs.gain_loop_setup[audio_sync_pkg::DECAY_DOWN_LSB +: 2])
      2'h0: agc_down_decay_ms = audio_sync_pkg::DOWN_DECAY_0_MS;
      2'h1: agc_down_decay_ms = audio_sync_pkg::DOWN_DECAY_1_MS;
      2'h2: agc_down_decay_ms = audio_sync_pkg::DOWN_DECAY_2_MS;
      2'h3: agc_down_decay_ms = audio_sync_pkg::DOWN_DECAY_3_MS;
    endcase
    unique case (s.regs.gain_loop_setup[audio_sync_pkg::DECAY_UP_LSB +: 2])
      2'h0: agc_up_decay_ms = audio_sync_pkg::UP_DECAY_0_MS;
      2'h1: agc_up_decay_ms = audio_sync_pkg::UP_DECAY_1_MS;
      2'h2: agc_up_decay_ms = audio_sync_pkg::UP_DECAY_2_MS;
      2'h3: agc_up_decay_ms = audio_sync_pkg::UP_DECAY_3_MS;
    endcase
    unique case (s.regs.sync_effect_setup[audio_sync_pkg::AUDIO_DECAY_LSB +: 2])
      2'h0: audio_decay_ms = audio_sync_pkg::AUDIO_DECAY_0_MS;
      2'h1: audio_decay_ms = audio_sync_pkg::AUDIO_DECAY_1_MS;
      2'h2: audio_decay_ms = audio_sync_pkg::AUDIO_DECAY_2_MS;
      2'h3: audio_decay_ms = audio_sync_pkg::AUDIO_DECAY_3_MS;
    endcase
  end

  assign precharge_manual = s.regs.input_buffer_setup[audio_sync_pkg::PRECHARGE_MANUAL_BIT];
  assign precharge_enable = ~precharge_manual |
    ~s.regs.input_buffer_setup[audio_sync_pkg::PRECHARGE_OFF_BIT];
  assign preamp_gain_db = $signed({1'b0, s.regs.input_buffer_setup[audio_sync_pkg::GAIN_LSB +: 5]})
    - audio_sync_pkg::GAIN_OFFSET_DB;
  assign agc_gain_min_db = preamp_gain_db - audio_sync_pkg::AGC_RANGE_DB;
  assign agc_gain_max_db = preamp_gain_db + audio_sync_pkg::AGC_RANGE_DB;
  assign audio_buffer_on = s.regs.input_buffer_setup[audio_sync_pkg::BUFFER_ON_BIT];
  assign source_is_fourth_current_output =
    s.regs.sync_effect_setup[audio_sync_pkg::SOURCE_PIN_BIT];
  assign pulldown_enable = ~s.regs.sync_effect_setup[audio_sync_pkg::PULLDOWN_OFF_BIT] &
    ~audio_buffer_on & ~audio_mode_active;
  assign sync_effect = audio_sync_pkg::sync_effect_e'(
    s.regs.sync_effect_setup[audio_sync_pkg::EFFECT_LSB +: 3]);
  assign effect_valid = (sync_effect != audio_sync_pkg::EFFECT_RESERVED);
  assign out1_sound_drive = s.regs.channel_source_select[0];
  assign out2_sound_drive = s.regs.channel_source_select[1];
  assign out3_sound_drive = s.regs.channel_source_select[2];
  assign out4_sound_drive = s.regs.channel_source_select[3];

  channel_source_mux u_mux (
    .clk(clk),
    .reset(reset),
    .sound_select(s.regs.channel_source_select[3:0]),
    .pattern_level(pattern_level),
    .sound_level(sound_level),
    .drive_level(drive_level)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence seq_gain_write;
    wr_fire && s.ptr == audio_sync_pkg::GAIN_LOOP_OFFSET;
  endsequence
  sequence seq_buffer_write;
    wr_fire && s.ptr == audio_sync_pkg::INPUT_BUFFER_OFFSET;
  endsequence
  a_up_thresh: assert property (seq_gain_write |=>
    agc_up_threshold_high == $past(s.shift[6])) else $error("Up threshold not written.");
  a_down_thresh: assert property (seq_gain_write |=>
    agc_down_threshold_high == $past(s.shift[5])) else $error("Down threshold not written.");
  a_down_decay: assert property (seq_gain_write ##1
    (s.regs.gain_loop_setup[4:3] == 2'h3) |-> agc_down_decay_ms == 11'h20C)
    else $error("Longest down decay is not 524 ms.");
  a_up_decay: assert property ((s.regs.gain_loop_setup[2:1] == 2'h0) |->
    agc_up_decay_ms == 11'h106) else $error("Shortest up decay is not 262 ms.");
  a_agc_enable: assert property (seq_gain_write |=> agc_enable == $past(s.shift[0]))
    else $error("AGC enable does not follow write.");
  a_precharge_gate: assert property (!precharge_manual |-> precharge_enable)
    else $error("Precharge blocked while automatic.");
  a_precharge_mode: assert property (seq_buffer_write |=>
    precharge_manual == $past(s.shift[6])) else $error("Precharge mode not written.");
  a_gain_map: assert property (seq_buffer_write ##1
    (s.regs.input_buffer_setup[5:1] == 5'h1F) |-> preamp_gain_db == 6'sh19)
    else $error("Top gain code is not 25 dB.");
  a_pulldown_off: assert property ((audio_mode_active || audio_buffer_on) |->
    !pulldown_enable) else $error("Pull-down on in audio mode or with buffer on.");
  a_audio_decay: assert property ((s.regs.sync_effect_setup[4:3] == 2'h2) |->
    audio_decay_ms == 7'h28) else $error("Audio decay code 2 is not 40 ms.");
  a_effect_reserved: assert property ((s.regs.sync_effect_setup[2:0] == 3'h7) |->
    !effect_valid) else $error("Reserved effect reported valid.");
  a_agc_window: assert property (
    agc_gain_max_db - agc_gain_min_db == 6'sh06 && agc_gain_min_db + 6'sh03 == preamp_gain_db)
    else $error("AGC window not centred 3 dB about gain.");
  a_reset_zero: assert property ($fell(reset) |-> s.regs == '0 && sda_drive_n)
    else $error("Registers not zero after reset.");
  a_reserved_zero: assert property (
    s.regs.channel_source_select[7:4] == 4'h0 && s.regs.gain_loop_setup[7] == 1'b0)
    else $error("Reserved bit holds a one.");

endmodule

// ---- audio_sync_pkg.sv ----
package audio_sync_pkg;

  // Two-wire slave address of the device.
  localparam logic [6:0] DEVICE_ADDR = 7'h2A;

  // Register offsets.
  localparam logic [7:0] GAIN_LOOP_OFFSET = 8'h40;
  localparam logic [7:0] INPUT_BUFFER_OFFSET = 8'h41;
  localparam logic [7:0] SYNC_EFFECT_OFFSET = 8'h42;
  localparam logic [7:0] CHANNEL_SOURCE_OFFSET = 8'h43;

  // Reset values.
  localparam logic [7:0] GAIN_LOOP_RESET = 8'h00;
  localparam logic [7:0] INPUT_BUFFER_RESET = 8'h00;
  localparam logic [7:0] SYNC_EFFECT_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_SOURCE_RESET = 8'h00;

  // Writable bits; everything else is reserved.
  localparam logic [7:0] GAIN_LOOP_MASK = 8'h7F;
  localparam logic [7:0] INPUT_BUFFER_MASK = 8'hFF;
  localparam logic [7:0] SYNC_EFFECT_MASK = 8'hDF;
  localparam logic [7:0] CHANNEL_SOURCE_MASK = 8'h0F;

  // Field positions.
  localparam int AGC_UP_LEVEL_BIT = 6;
  localparam int AGC_DOWN_LEVEL_BIT = 5;
  localparam int DECAY_DOWN_LSB = 3;
  localparam int DECAY_UP_LSB = 1;
  localparam int AGC_ON_BIT = 0;
  localparam int PRECHARGE_OFF_BIT = 7;
  localparam int PRECHARGE_MANUAL_BIT = 6;
  localparam int GAIN_LSB = 1;
  localparam int BUFFER_ON_BIT = 0;
  localparam int SOURCE_PIN_BIT = 7;
  localparam int PULLDOWN_OFF_BIT = 6;
  localparam int AUDIO_DECAY_LSB = 3;
  localparam int EFFECT_LSB = 0;

  // Decay times in milliseconds.
  localparam logic [10:0] DOWN_DECAY_0_MS = 11'h083;
  localparam logic [10:0] DOWN_DECAY_1_MS = 11'h106;
  localparam logic [10:0] DOWN_DECAY_2_MS = 11'h189;
  localparam logic [10:0] DOWN_DECAY_3_MS = 11'h20C;
  localparam logic [10:0] UP_DECAY_0_MS = 11'h106;
  localparam logic [10:0] UP_DECAY_1_MS = 11'h20C;
  localparam logic [10:0] UP_DECAY_2_MS = 11'h312;
  localparam logic [10:0] UP_DECAY_3_MS = 11'h419;
  localparam logic [6:0] AUDIO_DECAY_0_MS = 7'h0A;
  localparam logic [6:0] AUDIO_DECAY_1_MS = 7'h14;
  localparam logic [6:0] AUDIO_DECAY_2_MS = 7'h28;
  localparam logic [6:0] AUDIO_DECAY_3_MS = 7'h50;

  // Gain mapping in dB.
  localparam logic signed [5:0] GAIN_OFFSET_DB = 6'sh06;
  localparam logic signed [5:0] AGC_RANGE_DB = 6'sh03;

  typedef enum logic [2:0] {
    EFFECT_BAR = 3'h0,
    EFFECT_BAR_DIM = 3'h1,
    EFFECT_RUNNING = 3'h2,
    EFFECT_RUNNING_DIM = 3'h3,
    EFFECT_RGB = 3'h4,
    EFFECT_RGB_DIM = 3'h5,
    EFFECT_PARALLEL_DIM = 3'h6,
    EFFECT_RESERVED = 3'h7
  } sync_effect_e;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PTR_ACK = 9'h010,
    ST_WRITE = 9'h020,
    ST_WRITE_ACK = 9'h040,
    ST_READ = 9'h080,
    ST_READ_ACK = 9'h100
  } bus_state_e;

  typedef struct packed {
    logic [7:0] gain_loop_setup;
    logic [7:0] input_buffer_setup;
    logic [7:0] sync_effect_setup;
    logic [7:0] channel_source_select;
  } audio_regs_s;

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    bus_state_e fsm;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic drive;
    logic [7:0] ptr;
    audio_regs_s regs;
  } ctrl_state_s;

  typedef struct packed {
    logic [3:0] level;
  } mux_state_s;

endpackage

// ---- channel_source_mux.sv ----
`timescale 1ns/1ps
module channel_source_mux (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] sound_select,
  input wire logic [3:0] pattern_level,
  input wire logic [3:0] sound_level,
  output logic [3:0] drive_level
);

  audio_sync_pkg::mux_state_s s;
  audio_sync_pkg::mux_state_s next_s;
  logic [3:0] next_level;

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_chan
      assign next_level[i] = sound_select[i] ? sound_level[i] : pattern_level[i];
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.level = next_level;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign drive_level = s.level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_audio_route: assert property (sound_select[0] |=>
    drive_level[0] == $past(sound_level[0]))
    else $error("Audio channel one not routed from audio unit.");
  a_pattern_route: assert property (!sound_select[3] |=>
    drive_level[3] == $past(pattern_level[3]))
    else $error("Channel four in normal mode not routed from pattern.");

endmodule

// ---- host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hp();
    repeat (4) @(negedge clk);
  endtask

  // One serial clock period: the line is set while the clock is low, sampled mid-high.
  task automatic clk_bit(input logic v, output logic s);
    sda_low = !v;
    hp();
    scl = 1'b1;
    hp();
    s = sda;
    hp();
    scl = 1'b0;
    hp();
  endtask

  task automatic bus_start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask

  task automatic bus_stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, ack);
  endtask

  task automatic get_byte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(last, s);
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] off;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [3:0] sel;
    logic [10:0] ex;
  } row_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic audio_mode_active = 1'b0;
  logic [3:0] pattern_level = 4'h0;
  logic [3:0] sound_level = 4'h0;
  logic scl, sda_low, sda, sda_drive_n, agc_up_threshold_high, agc_down_threshold_high;
  logic agc_enable, precharge_manual, precharge_enable, audio_buffer_on, pulldown_enable;
  logic source_is_fourth_current_output, effect_valid, out1_sound_drive, out2_sound_drive;
  logic out3_sound_drive, out4_sound_drive, sda_out;
  logic [3:0] drive_level;
  logic [10:0] agc_down_decay_ms, agc_up_decay_ms;
  logic signed [5:0] preamp_gain_db, agc_gain_min_db, agc_gain_max_db;
  logic [6:0] audio_decay_ms;
  audio_sync_pkg::sync_effect_e sync_effect;
  logic [7:0] d;
  int n_fail = 0;
  int checks_done = 0;
  row_s rows [30] = '{
    '{8'h40, 8'hC0, 8'h40, 4'h1, 11'h001},
    '{8'h40, 8'h20, 8'h20, 4'h2, 11'h001},
    '{8'h40, 8'h00, 8'h00, 4'h3, 11'h083},
    '{8'h40, 8'h08, 8'h08, 4'h3, 11'h106},
    '{8'h40, 8'h10, 8'h10, 4'h3, 11'h189},
    '{8'h40, 8'h18, 8'h18, 4'h3, 11'h20C},
    '{8'h40, 8'h00, 8'h00, 4'h4, 11'h106},
    '{8'h40, 8'h02, 8'h02, 4'h4, 11'h20C},
    '{8'h40, 8'h04, 8'h04, 4'h4, 11'h312},
    '{8'h40, 8'h06, 8'h06, 4'h4, 11'h419},
    '{8'h40, 8'h01, 8'h01, 4'h5, 11'h001},
    '{8'h41, 8'h40, 8'h40, 4'h6, 11'h001},
    '{8'h41, 8'h40, 8'h40, 4'h7, 11'h001},
    '{8'h41, 8'hC0, 8'hC0, 4'h7, 11'h000},
    '{8'h41, 8'h40, 8'h40, 4'h7, 11'h001},
    '{8'h41, 8'h80, 8'h80, 4'h7, 11'h001},
    '{8'h41, 8'h00, 8'h00, 4'h8, 11'h03A},
    '{8'h41, 8'h3E, 8'h3E, 4'h8, 11'h019},
    '{8'h41, 8'h3E, 8'h3E, 4'hA, 11'h01C},
    '{8'h41, 8'h3E, 8'h3E, 4'h9, 11'h016},
    '{8'h41, 8'h01, 8'h01, 4'hB, 11'h001},
    '{8'h41, 8'h01, 8'h01, 4'hD, 11'h000},
    '{8'h41, 8'h00, 8'h00, 4'hD, 11'h001},
    '{8'h42, 8'h40, 8'h40, 4'hD, 11'h000},
    '{8'h42, 8'h80, 8'h80, 4'hC, 11'h001},
    '{8'h42, 8'h20, 8'h00, 4'hE, 11'h00A},
    '{8'h42, 8'h08, 8'h08, 4'hE, 11'h014},
    '{8'h42, 8'h10, 8'h10, 4'hE, 11'h028},
    '{8'h42, 8'h18, 8'h18, 4'hE, 11'h050},
    '{8'h43, 8'hFF, 8'h0F, 4'hF, 11'h00F}
  };

  always #25 clk = ~clk;
  // Open-drain data line with a pull-up: low while either party pulls it low.
  assign sda = !sda_low && (sda_drive_n || sda_out);

  host_bus_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  audio_sync_control_regs uut (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_drive_n(sda_drive_n), .audio_mode_active(audio_mode_active),
    .pattern_level(pattern_level), .sound_level(sound_level), .drive_level(drive_level),
    .agc_up_threshold_high(agc_up_threshold_high),
    .agc_down_threshold_high(agc_down_threshold_high),
    .agc_down_decay_ms(agc_down_decay_ms), .agc_up_decay_ms(agc_up_decay_ms),
    .agc_enable(agc_enable), .precharge_manual(precharge_manual),
    .precharge_enable(precharge_enable), .preamp_gain_db(preamp_gain_db),
    .agc_gain_min_db(agc_gain_min_db), .agc_gain_max_db(agc_gain_max_db),
    .audio_buffer_on(audio_buffer_on),
    .source_is_fourth_current_output(source_is_fourth_current_output),
    .pulldown_enable(pulldown_enable), .audio_decay_ms(audio_decay_ms),
    .sync_effect(sync_effect), .effect_valid(effect_valid),
    .out1_sound_drive(out1_sound_drive), .out2_sound_drive(out2_sound_drive),
    .out3_sound_drive(out3_sound_drive), .out4_sound_drive(out4_sound_drive)
  );

  function automatic logic [10:0] got(input logic [3:0] s);
    case (s)
      4'h1: got = {10'h000, agc_up_threshold_high};
      4'h2: got = {10'h000, agc_down_threshold_high};
      4'h3: got = agc_down_decay_ms;
      4'h4: got = agc_up_decay_ms;
      4'h5: got = {10'h000, agc_enable};
      4'h6: got = {10'h000, precharge_manual};
      4'h7: got = {10'h000, precharge_enable};
      4'h8: got = {5'h00, preamp_gain_db};
      4'h9: got = {5'h00, agc_gain_min_db};
      4'hA: got = {5'h00, agc_gain_max_db};
      4'hB: got = {10'h000, audio_buffer_on};
      4'hC: got = {10'h000, source_is_fourth_current_output};
      4'hD: got = {10'h000, pulldown_enable};
      4'hE: got = {4'h0, audio_decay_ms};
      4'hF: got = {7'h00, out4_sound_drive, out3_sound_drive, out2_sound_drive, out1_sound_drive};
      default: got = 11'h000;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] off, input logic [7:0] wd);
    logic a1, a2, a3;
    host.bus_start();
    host.put_byte({audio_sync_pkg::DEVICE_ADDR, 1'b0}, a1);
    host.put_byte(off, a2);
    host.put_byte(wd, a3);
    host.bus_stop();
    chk("write acks", 11'h000, {8'h00, a1, a2, a3});
  endtask

  task automatic reg_rd(input logic [7:0] off, output logic [7:0] rd);
    logic a1, a2, a3;
    host.bus_start();
    host.put_byte({audio_sync_pkg::DEVICE_ADDR, 1'b0}, a1);
    host.put_byte(off, a2);
    host.bus_start();
    host.put_byte({audio_sync_pkg::DEVICE_ADDR, 1'b1}, a3);
    host.get_byte(rd, 1'b1);
    host.bus_stop();
    chk("read acks", 11'h000, {8'h00, a1, a2, a3});
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    do_reset();
    chk("reset down decay", 11'h083, agc_down_decay_ms);
    chk("reset gain", 11'h03A, {5'h00, preamp_gain_db});
    chk("reset pulldown", 11'h001, {10'h000, pulldown_enable});
    for (int i = 0; i < 4; i++) begin
      reg_rd(8'h40 + 8'(i), d);
      chk("reset value", 11'h000, {3'h0, d});
    end
    foreach (rows[i]) begin
      reg_wr(rows[i].off, rows[i].wd);
      chk("decoded output", rows[i].ex, got(rows[i].sel)); // per row
      reg_rd(rows[i].off, d);
      chk("readback", {3'h0, rows[i].rd}, {3'h0, d});
    end
    audio_mode_active = 1'b1;
    #1 chk("pulldown in audio mode", 11'h000, {10'h000, pulldown_enable});
    audio_mode_active = 1'b0;
    #1 chk("pulldown out of audio mode", 11'h001, {10'h000, pulldown_enable});
    for (int e = 0; e < 8; e++) begin
      reg_wr(8'h42, 8'(e));
      chk("effect", 11'(e), {8'h00, sync_effect});
      chk("effect valid", {10'h000, e != 7}, {10'h000, effect_valid});
    end
    reg_rd(8'h44, d);
    chk("unmapped read", 11'h000, {3'h0, d});
    reg_wr(8'h43, 8'h03);
    @(negedge clk);
    pattern_level = 4'h5;
    sound_level = 4'hA;
    repeat (2) @(negedge clk);
    chk("drive level mixed", 11'h006, {7'h00, drive_level});
    sound_level = 4'h5;
    repeat (2) @(negedge clk);
    chk("drive level follows", 11'h005, {7'h00, drive_level});
    do_reset();
    reg_rd(8'h43, d);
    chk("second reset", 11'h000, {3'h0, d});
    chk("second reset mux", 11'h005, {7'h00, drive_level});
    conclude();
  end
endmodule
